// file: shared/cmsd_pkg.sv
// Constants and carrier types shared by the core memory space decoder files.
package cmsd_pkg;
  // Special-function addresses of the registers kept inside this block.
  localparam logic [7:0] CMSD_SFR_PROG_BANK = 8'hB1;
  localparam logic [7:0] CMSD_SFR_STACK_PTR = 8'h81;
  localparam logic [7:0] CMSD_SFR_PAGE_SEL = 8'h84;
  localparam logic [7:0] CMSD_SFR_STORE_CTL = 8'h8F;
  localparam logic [7:0] CMSD_SFR_STATUS_WORD = 8'hD0;
  // Values after reset.
  localparam logic [7:0] CMSD_PROG_BANK_RESET = 8'h11;
  localparam logic [7:0] CMSD_STACK_PTR_RESET = 8'h07;
  localparam logic [7:0] CMSD_PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] CMSD_STORE_CTL_RESET = 8'h00;
  localparam logic [7:0] CMSD_STATUS_WORD_RESET = 8'h00;
  // Field positions.
  localparam int CMSD_CONST_BANK_LSB = 4;
  localparam int CMSD_FETCH_BANK_LSB = 0;
  localparam int CMSD_REG_BANK_LSB = 3;
  localparam int CMSD_STORE_WEN_BIT = 0;
  // Data memory landmarks.
  localparam logic [7:0] CMSD_BIT_AREA_BASE = 8'h20;
  // Implemented special-function pages; the store control register lives on page 0.
  localparam logic [7:0] CMSD_PAGE_0 = 8'h00;
  localparam logic [7:0] CMSD_PAGE_1 = 8'h01;
  localparam logic [7:0] CMSD_PAGE_2 = 8'h02;
  localparam logic [7:0] CMSD_PAGE_3 = 8'h03;
  localparam logic [7:0] CMSD_PAGE_F = 8'h0F;
  localparam int CMSD_RECORD_DEPTH = 32;

  typedef enum logic [2:0] {
    CMSD_MODE_DIRECT = 3'h0,
    CMSD_MODE_INDIRECT = 3'h1,
    CMSD_MODE_PTR = 3'h3,
    CMSD_MODE_REG = 3'h2,
    CMSD_MODE_BIT = 3'h6
  } cmsd_mode_e;

  typedef struct packed {
    logic valid;
    cmsd_mode_e mode;
    logic [7:0] addr;
    logic write;
    logic [7:0] wdata;
  } cmsd_data_req_s;

  typedef struct packed {
    logic ram_sel;
    logic sfr_sel;
    logic is_bit;
    logic bit_capable;
    logic [7:0] addr;
    logic [7:0] bit_mask;
    logic [7:0] page;
  } cmsd_data_sel_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic code_constant_read;
    logic write;
    logic scratch;
  } cmsd_code_req_s;

  typedef struct packed {
    logic push;
    logic pop;
    logic call;
    logic ret;
    logic inc;
    logic dec;
  } cmsd_stack_op_s;
endpackage : cmsd_pkg

// file: rtl/cmsd_bank_map.sv
// Maps a 16-bit code address and a bank code onto the flat Flash address.
module cmsd_bank_map #(
  parameter int ADDR_W = 16,
  parameter int BANK_W = 2
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [BANK_W-1:0] bank_i,
  output logic [ADDR_W+BANK_W-2:0] flash_addr_o
);
  import cmsd_pkg::*;

  localparam int TOP = ADDR_W + BANK_W - 2;

  // The lower half always reaches bank 0; the upper window follows the bank code.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flash_addr_o <= '0;
    end else if (addr_i[ADDR_W-1]) begin
      flash_addr_o <= {bank_i, addr_i[ADDR_W-2:0]}; // see RULE1 RULE3
    end else begin
      flash_addr_o <= {{BANK_W{1'b0}}, addr_i[ADDR_W-2:0]}; // see RULE5
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_lower_common: assert property (!addr_i[ADDR_W-1] |=> // see RULE5
    flash_addr_o[TOP:ADDR_W-1] == '0)
    else $error("lower half did not map to bank 0");
  a_upper_bank: assert property (addr_i[ADDR_W-1] |=> // see RULE3
    flash_addr_o[TOP:ADDR_W-1] == $past(bank_i) &&
    flash_addr_o[ADDR_W-2:0] == $past(addr_i[ADDR_W-2:0]))
    else $error("upper window did not follow bank code");
endmodule : cmsd_bank_map

// file: rtl/cmsd_stack_record.sv
// Debug stack-record shift register with overflow and underflow detection.
module cmsd_stack_record #(
  parameter int DEPTH = cmsd_pkg::CMSD_RECORD_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input cmsd_pkg::cmsd_stack_op_s op_i,
  input wire logic clear_i,
  output logic [DEPTH-1:0] record_o,
  output logic overflow_o,
  output logic underflow_o
);
  import cmsd_pkg::*;

  localparam int CW = $clog2(DEPTH + 1) + 1;

  logic [CW-1:0] count;
  logic [CW-1:0] add_n;
  logic [CW-1:0] sub_n;
  logic over;
  logic under;

  // Calls take two record bits, single-byte moves take one.
  always_comb begin
    add_n = op_i.call ? CW'(2) : CW'(op_i.push | op_i.inc); // see RULE16
    sub_n = op_i.ret ? CW'(2) : CW'(op_i.pop | op_i.dec); // see RULE16
    over = (count + add_n) > CW'(DEPTH);
    under = count < sub_n;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      record_o <= '0;
      count <= '0;
    end else if (add_n != '0) begin
      record_o <= op_i.call ? {record_o[DEPTH-3:0], 2'b11} : {record_o[DEPTH-2:0], 1'b0};
      count <= over ? CW'(DEPTH) : count + add_n;
    end else if (sub_n != '0) begin
      record_o <= op_i.ret ? {2'b00, record_o[DEPTH-1:2]} : {1'b0, record_o[DEPTH-1:1]};
      count <= under ? '0 : count - sub_n;
    end
  end

  // Sticky flags for the debug logic; a new event wins over a clear.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      overflow_o <= 1'b0;
      underflow_o <= 1'b0;
    end else begin
      overflow_o <= (add_n != '0 && over) | (overflow_o & ~clear_i); // see RULE17
      underflow_o <= (add_n == '0 && sub_n != '0 && under) | (underflow_o & ~clear_i); // see RULE17
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_record_overflow: assert property (op_i.push && count == CW'(DEPTH) |=> overflow_o) // see RULE17
    else $error("overflow not flagged");
  a_record_underflow: assert property (op_i.ret && !op_i.call && !op_i.push && !op_i.inc
    && count < CW'(2) |=> underflow_o) // see RULE17
    else $error("underflow not flagged");
  a_call_two_bits: assert property (op_i.call && count <= CW'(DEPTH - 2) |=> // see RULE16
    count == $past(count) + CW'(2) && record_o[1:0] == 2'b11)
    else $error("call did not record two bits");
  c_record_full: cover property (count == CW'(DEPTH));
endmodule : cmsd_stack_record

// file: rtl/cmsd_decoder.sv
// Memory space decoder: Flash banking, internal RAM map, SFR paging, stack.
//
// Operation
// RULE1: constant bank field bits 5:4 picks the Flash bank for upper-window constants.
// RULE2: scratchpad constant accesses ignore the constant bank field.
// RULE3: fetch bank field bits 1:0 picks the Flash bank for upper-window fetches.
// RULE4: fetch bank field changes only when written from code in bank 0.
// RULE5: bank 0 always sits at 0x0000-0x7FFF; code 00 also maps it up.
// RULE6: program bank register at 0xB1 on all pages, reset 0x11, reserved bits zero.
// RULE7: the 64 kB part should keep both bank fields at 01.
// RULE8: internal RAM is 256 bytes; lower 128 direct or indirect.
// RULE9: above 0x7F, direct goes to SFR space, indirect to upper RAM.
// RULE10: 0x00-0x1F hold four register banks chosen by status word bits 4:3.
// RULE11: indirect pointers are only registers 0 and 1 of the active bank.
// RULE12: bytes 0x20-0x2F hold bits 0x00-0x7F, eight per byte.
// RULE13: bit operands give single-bit accesses, byte operands byte accesses.
// RULE14: stack pointer marks last used byte; push writes pointer plus one.
// RULE15: reset loads stack pointer 0x07 so the first push lands at 0x08.
// RULE16: stack record takes one bit per push, two per call, and gives back alike.
// RULE17: stack record overflow and underflow are flagged to debug at full speed.
// RULE18: SFRs whose address ends in 0 or 8 are also bit-addressable.
// RULE19: software keeps away from unoccupied SFR addresses.
// RULE20: SFR space is paged by the page select; pages 0,1,2,3,F exist.
// RULE21: software sets the page first, then uses a direct move.
// RULE22: data-move writes go to Flash only while store write enable is set.
// RULE23: page select is eight bits; paged SFRs answer only on their page.
module cmsd_decoder (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic [15:0] exec_pc_i,
  output logic [16:0] fetch_flash_addr_o,
  input cmsd_pkg::cmsd_code_req_s code_req_i,
  output logic const_flash_valid_o,
  output logic const_flash_write_o,
  output logic const_scratch_o,
  output logic [16:0] const_flash_addr_o,
  output logic xdata_valid_o,
  output logic xdata_write_o,
  output logic [15:0] xdata_addr_o,
  input cmsd_pkg::cmsd_data_req_s data_req_i,
  output cmsd_pkg::cmsd_data_sel_s data_sel_o,
  output logic sfr_rdata_valid_o,
  output logic [7:0] sfr_rdata_o,
  input cmsd_pkg::cmsd_stack_op_s stack_op_i,
  output logic stack_addr_valid_o,
  output logic [7:0] stack_addr_o,
  output logic [7:0] stack_pointer_o,
  input wire logic record_clear_i,
  output logic [31:0] record_o,
  output logic record_overflow_o,
  output logic record_underflow_o
);
  import cmsd_pkg::*;

  logic [1:0] constant_bank_field;
  logic [1:0] fetch_bank_field;
  logic [7:0] stack_pointer;
  logic [7:0] sfr_page_select;
  logic [7:0] program_store_control;
  logic [7:0] program_status_word;
  logic [1:0] reg_bank;
  logic [1:0] const_bank;
  logic [7:0] prog_bank_view;
  cmsd_data_sel_s next_sel;
  logic sfr_access;
  logic int_hit;
  logic page_known;
  logic [7:0] int_rdata;
  logic [7:0] merged;
  logic int_wr;
  logic [7:0] next_sp;
  logic stack_move;

  assign reg_bank = {program_status_word[CMSD_REG_BANK_LSB+1], // see RULE10
    program_status_word[CMSD_REG_BANK_LSB]};
  assign prog_bank_view = {2'b00, constant_bank_field, 2'b00, fetch_bank_field}; // see RULE6
  assign const_bank = code_req_i.scratch ? 2'b00 : constant_bank_field; // see RULE2
  assign stack_pointer_o = stack_pointer;

  cmsd_bank_map #(.ADDR_W(16), .BANK_W(2)) u_fetch_map (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .addr_i(fetch_addr_i),
    .bank_i(fetch_bank_field),
    .flash_addr_o(fetch_flash_addr_o)
  );

  cmsd_bank_map #(.ADDR_W(16), .BANK_W(2)) u_const_map (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .addr_i(code_req_i.addr),
    .bank_i(const_bank),
    .flash_addr_o(const_flash_addr_o)
  );

  cmsd_stack_record #(.DEPTH(CMSD_RECORD_DEPTH)) u_record (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .op_i(stack_op_i),
    .clear_i(record_clear_i),
    .record_o(record_o),
    .overflow_o(record_overflow_o),
    .underflow_o(record_underflow_o)
  );

  // Constant reads always use Flash; data-move writes only with store write enable.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      const_flash_valid_o <= 1'b0;
      const_flash_write_o <= 1'b0;
      const_scratch_o <= 1'b0;
      xdata_valid_o <= 1'b0;
      xdata_write_o <= 1'b0;
      xdata_addr_o <= 16'h0000;
    end else begin
      const_flash_valid_o <= code_req_i.valid & (code_req_i.code_constant_read |
        (code_req_i.write & program_store_control[CMSD_STORE_WEN_BIT])); // see RULE22
      const_flash_write_o <= code_req_i.valid & code_req_i.write & ~code_req_i.code_constant_read &
        program_store_control[CMSD_STORE_WEN_BIT]; // see RULE22
      const_scratch_o <= code_req_i.valid & code_req_i.scratch;
      xdata_valid_o <= code_req_i.valid & ~code_req_i.code_constant_read &
        ~(code_req_i.write & program_store_control[CMSD_STORE_WEN_BIT]); // see RULE22
      xdata_write_o <= code_req_i.valid & ~code_req_i.code_constant_read & code_req_i.write &
        ~program_store_control[CMSD_STORE_WEN_BIT];
      xdata_addr_o <= code_req_i.addr;
    end
  end

  // Data address decode by addressing mode.
  always_comb begin
    next_sel = '0;
    next_sel.page = sfr_page_select;
    next_sel.bit_mask = 8'hFF;
    sfr_access = 1'b0;
    case (data_req_i.mode)
      CMSD_MODE_DIRECT: begin
        sfr_access = data_req_i.addr[7]; // see RULE9
        next_sel.addr = data_req_i.addr;
        next_sel.bit_capable = data_req_i.addr[7] & (data_req_i.addr[2:0] == 3'h0); // see RULE18
      end
      CMSD_MODE_INDIRECT: begin
        next_sel.addr = data_req_i.addr; // see RULE8 RULE9
      end
      CMSD_MODE_REG: begin
        next_sel.addr = {3'h0, reg_bank, data_req_i.addr[2:0]}; // see RULE10
      end
      CMSD_MODE_PTR: begin
        next_sel.addr = {3'h0, reg_bank, 2'h0, data_req_i.addr[0]}; // see RULE11
      end
      CMSD_MODE_BIT: begin
        next_sel.is_bit = 1'b1; // see RULE13
        next_sel.bit_capable = 1'b1;
        next_sel.bit_mask = 8'h01 << data_req_i.addr[2:0];
        sfr_access = data_req_i.addr[7];
        if (data_req_i.addr[7]) begin
          next_sel.addr = {data_req_i.addr[7:3], 3'h0}; // see RULE18
        end else begin
          next_sel.addr = CMSD_BIT_AREA_BASE + {4'h0, data_req_i.addr[6:3]}; // see RULE12
        end
      end
      default: begin
        next_sel.addr = data_req_i.addr;
      end
    endcase
  end

  // Registers held here and which pages they answer on.
  always_comb begin
    int_hit = 1'b1;
    int_rdata = 8'h00;
    case (next_sel.addr)
      CMSD_SFR_PROG_BANK: int_rdata = prog_bank_view; // see RULE6
      CMSD_SFR_STACK_PTR: int_rdata = stack_pointer;
      CMSD_SFR_PAGE_SEL: int_rdata = sfr_page_select;
      CMSD_SFR_STATUS_WORD: int_rdata = program_status_word;
      CMSD_SFR_STORE_CTL: begin
        int_hit = (sfr_page_select == CMSD_PAGE_0); // see RULE23
        int_rdata = program_store_control;
      end
      default: int_hit = 1'b0;
    endcase
    page_known = sfr_page_select inside {CMSD_PAGE_0, CMSD_PAGE_1, CMSD_PAGE_2,
      CMSD_PAGE_3, CMSD_PAGE_F}; // see RULE20
    merged = next_sel.is_bit ? ((int_rdata & ~next_sel.bit_mask) |
      (data_req_i.wdata[0] ? next_sel.bit_mask : 8'h00)) : data_req_i.wdata; // see RULE13
    int_wr = data_req_i.valid & data_req_i.write & sfr_access & int_hit;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      data_sel_o <= '0;
      sfr_rdata_valid_o <= 1'b0;
      sfr_rdata_o <= 8'h00;
    end else begin
      data_sel_o <= next_sel;
      data_sel_o.ram_sel <= data_req_i.valid & ~sfr_access; // see RULE8 RULE9
      data_sel_o.sfr_sel <= data_req_i.valid & sfr_access & ~int_hit & page_known; // see RULE23
      sfr_rdata_valid_o <= data_req_i.valid & ~data_req_i.write & sfr_access & int_hit;
      sfr_rdata_o <= int_rdata;
    end
  end

  // Program bank register; the fetch field only moves under code from bank 0.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      constant_bank_field <= CMSD_PROG_BANK_RESET[CMSD_CONST_BANK_LSB+:2];
      fetch_bank_field <= CMSD_PROG_BANK_RESET[CMSD_FETCH_BANK_LSB+:2];
    end else if (int_wr && next_sel.addr == CMSD_SFR_PROG_BANK) begin
      constant_bank_field <= merged[CMSD_CONST_BANK_LSB+:2]; // see RULE1
      if (!exec_pc_i[15]) begin
        fetch_bank_field <= merged[CMSD_FETCH_BANK_LSB+:2]; // see RULE4
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sfr_page_select <= CMSD_PAGE_SEL_RESET;
      program_store_control <= CMSD_STORE_CTL_RESET;
      program_status_word <= CMSD_STATUS_WORD_RESET;
    end else if (int_wr) begin
      if (next_sel.addr == CMSD_SFR_PAGE_SEL) begin
        sfr_page_select <= merged; // see RULE23
      end
      if (next_sel.addr == CMSD_SFR_STORE_CTL) begin
        program_store_control <= {7'h00, merged[CMSD_STORE_WEN_BIT]};
      end
      if (next_sel.addr == CMSD_SFR_STATUS_WORD) begin
        program_status_word <= merged;
      end
    end
  end

  // Stack pointer; stack operations win over a software write in the same cycle.
  always_comb begin
    stack_move = |{stack_op_i.push, stack_op_i.inc, stack_op_i.call,
      stack_op_i.pop, stack_op_i.dec, stack_op_i.ret};
    if (stack_op_i.call) begin
      next_sp = stack_pointer + 8'h02;
    end else if (stack_op_i.push || stack_op_i.inc) begin
      next_sp = stack_pointer + 8'h01; // see RULE14
    end else if (stack_op_i.ret) begin
      next_sp = stack_pointer - 8'h02;
    end else if (stack_op_i.pop || stack_op_i.dec) begin
      next_sp = stack_pointer - 8'h01;
    end else if (int_wr && next_sel.addr == CMSD_SFR_STACK_PTR) begin
      next_sp = merged;
    end else begin
      next_sp = stack_pointer;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      stack_pointer <= CMSD_STACK_PTR_RESET; // see RULE15
      stack_addr_valid_o <= 1'b0;
      stack_addr_o <= 8'h00;
    end else begin
      stack_pointer <= next_sp;
      stack_addr_valid_o <= stack_op_i.push | stack_op_i.call | stack_op_i.pop | stack_op_i.ret;
      if (stack_op_i.push || stack_op_i.call) begin
        stack_addr_o <= stack_pointer + 8'h01; // see RULE14
      end else if (stack_op_i.pop || stack_op_i.ret) begin
        stack_addr_o <= stack_pointer;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_sp_reset_value: assert property ($rose(rst_b_i) |-> stack_pointer == 8'h07) // see RULE15
    else $error("stack pointer not 0x07 after reset");
  a_push_slot: assert property (stack_op_i.push && !stack_op_i.call |=> // see RULE14
    stack_addr_valid_o && stack_addr_o == $past(stack_pointer) + 8'h01 &&
    stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("push slot or pointer wrong");
  a_fetch_lock: assert property (exec_pc_i[15] && !$past(!rst_b_i) |=> // see RULE4
    fetch_bank_field == $past(fetch_bank_field))
    else $error("fetch bank changed from banked code");
  a_direct_high_sfr: assert property (data_req_i.valid && data_req_i.addr[7] && // see RULE9
    data_req_i.mode == CMSD_MODE_DIRECT |=> !data_sel_o.ram_sel)
    else $error("direct high access reached RAM");
  a_indirect_high_ram: assert property (data_req_i.valid && // see RULE9
    data_req_i.mode == CMSD_MODE_INDIRECT |=> data_sel_o.ram_sel && !data_sel_o.sfr_sel &&
    data_sel_o.addr == $past(data_req_i.addr))
    else $error("indirect access not sent to RAM");
  a_reg_bank_addr: assert property (data_req_i.valid && // see RULE10
    data_req_i.mode == CMSD_MODE_REG |=> data_sel_o.addr ==
    {3'h0, $past(program_status_word[4:3]), $past(data_req_i.addr[2:0])})
    else $error("register bank address wrong");
  a_bit_area_map: assert property (data_req_i.valid && data_req_i.mode == CMSD_MODE_BIT && // see RULE12
    !data_req_i.addr[7] |=> data_sel_o.ram_sel &&
    data_sel_o.addr == 8'h20 + {4'h0, $past(data_req_i.addr[6:3])} && data_sel_o.is_bit)
    else $error("bit area mapping wrong");
  a_store_gate: assert property (code_req_i.valid && code_req_i.write && !code_req_i.code_constant_read && // see RULE22
    !program_store_control[0] |=> !const_flash_valid_o && xdata_write_o)
    else $error("write reached Flash without enable");

  c_push_seen: cover property (stack_op_i.push ##1 stack_addr_valid_o);
  c_fetch_bank_set: cover property (int_wr && next_sel.addr == CMSD_SFR_PROG_BANK && !exec_pc_i[15]);
  c_sfr_bit: cover property (data_req_i.valid && data_req_i.mode == CMSD_MODE_BIT &&
    data_req_i.addr[7]);
  c_flash_write: cover property (const_flash_write_o);
endmodule : cmsd_decoder

// file: verif/cmsd_core_model.sv
// Core-side model that issues fetch, data, code-space and stack requests.
module cmsd_core_model (
  input wire logic clk_i,
  output cmsd_pkg::cmsd_data_req_s data_req_o,
  output cmsd_pkg::cmsd_code_req_s code_req_o,
  output cmsd_pkg::cmsd_stack_op_s stack_op_o,
  output logic [15:0] fetch_addr_o,
  output logic [15:0] exec_pc_o,
  output logic record_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmsd_pkg::*;

  initial begin
    data_req_o = '0;
    code_req_o = '0;
    stack_op_o = '0;
    fetch_addr_o = 16'h0000;
    exec_pc_o = 16'h0000;
    record_clear_o = 1'b0;
  end

  // Released fields other than the data mode show inverted values so that stale data is never mistaken for valid data.
  task automatic data_op(input cmsd_mode_e m, input logic [7:0] a, input logic w,
                         input logic [7:0] d);
    @(negedge clk_i);
    data_req_o <= '{1'b1, m, a, w, d};
    @(negedge clk_i);
    data_req_o <= '{1'b0, m, ~a, ~w, ~d};
  endtask : data_op

  task automatic code_op(input logic [15:0] a, input logic mv, input logic w, input logic s);
    @(negedge clk_i);
    code_req_o <= '{1'b1, a, mv, w, s};
    @(negedge clk_i);
    code_req_o <= '{1'b0, ~a, ~mv, ~w, ~s};
  endtask : code_op

  task automatic stack(input logic [5:0] op);
    @(negedge clk_i);
    stack_op_o <= op;
    @(negedge clk_i);
    stack_op_o <= '0;
  endtask : stack

  task automatic clear();
    @(negedge clk_i);
    record_clear_o <= 1'b1;
    @(negedge clk_i);
    record_clear_o <= 1'b0;
  endtask : clear

  task automatic fetch(input logic [15:0] a);
    @(negedge clk_i);
    fetch_addr_o <= a;
    @(negedge clk_i);
  endtask : fetch

  task automatic set_pc(input logic [15:0] p);
    @(negedge clk_i);
    exec_pc_o <= p;
  endtask : set_pc
endmodule : cmsd_core_model

// file: verif/tb_cmsd_decoder.sv
// Self-checking testbench for the core memory space decoder.
module tb_cmsd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import cmsd_pkg::*;
  logic clk_i;
  logic rst_b_i;
  cmsd_data_req_s data_req;
  cmsd_code_req_s code_req;
  cmsd_stack_op_s stack_op;
  cmsd_data_sel_s sel;
  logic [15:0] fetch_addr, exec_pc, x_addr;
  logic [16:0] fetch_fa, const_fa;
  logic rec_clr, cf_valid, cf_write, c_scratch, x_valid, x_write, rd_valid, st_valid, ovf, unf;
  logic [7:0] rdata, st_addr, sp;
  logic [31:0] rec;
  int err_total = 0;
  int compares = 0;

  cmsd_core_model cpu (.clk_i(clk_i), .data_req_o(data_req), .code_req_o(code_req),
    .stack_op_o(stack_op), .fetch_addr_o(fetch_addr), .exec_pc_o(exec_pc),
    .record_clear_o(rec_clr));

  cmsd_decoder dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .fetch_addr_i(fetch_addr),
    .exec_pc_i(exec_pc), .fetch_flash_addr_o(fetch_fa), .code_req_i(code_req),
    .const_flash_valid_o(cf_valid), .const_flash_write_o(cf_write), .const_scratch_o(c_scratch),
    .const_flash_addr_o(const_fa), .xdata_valid_o(x_valid), .xdata_write_o(x_write),
    .xdata_addr_o(x_addr), .data_req_i(data_req), .data_sel_o(sel),
    .sfr_rdata_valid_o(rd_valid), .sfr_rdata_o(rdata), .stack_op_i(stack_op),
    .stack_addr_valid_o(st_valid), .stack_addr_o(st_addr), .stack_pointer_o(sp),
    .record_clear_i(rec_clr), .record_o(rec), .record_overflow_o(ovf),
    .record_underflow_o(unf));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu.data_op(CMSD_MODE_DIRECT, a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cpu.data_op(CMSD_MODE_DIRECT, a, 1'b0, 8'h00);
    chk(32'({rd_valid, rdata}), 32'({1'b1, exp}));
  endtask : rd

  task automatic op(input cmsd_mode_e m, input logic [7:0] a);
    cpu.data_op(m, a, 1'b0, 8'h00);
  endtask : op

  task automatic t_reset();
    rd(CMSD_SFR_PROG_BANK, 8'h11);
    chk(32'({sp, rec[7:0]}), 32'h0700);
  endtask : t_reset

  task automatic t_banks();
    logic [1:0] b;
    cpu.set_pc(16'h7FFF);
    for (int c = 0; c < 4; c++) begin
      b = 2'(c);
      wr(CMSD_SFR_PROG_BANK, {2'b11, b, 2'b11, b});
      rd(CMSD_SFR_PROG_BANK, {2'b00, b, 2'b00, b});
      cpu.fetch(16'h9234);
      chk(32'(fetch_fa), 32'({b, 15'h1234}));
      cpu.fetch(16'h1234);
      chk(32'(fetch_fa), 32'({2'b00, 15'h1234}));
      cpu.code_op(16'hA000, 1'b1, 1'b0, 1'b0);
      chk(32'({cf_valid, x_valid, const_fa}), 32'({2'b10, b, 15'h2000}));
      cpu.code_op(16'hA000, 1'b1, 1'b0, 1'b1);
      chk(32'({c_scratch, const_fa}), 32'({3'b100, 15'h2000}));
    end
    cpu.set_pc(16'h8000);
    wr(CMSD_SFR_PROG_BANK, 8'h10);
    rd(CMSD_SFR_PROG_BANK, 8'h13);
    cpu.set_pc(16'h0000);
  endtask : t_banks

  task automatic t_space();
    logic [7:0] pg [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'h05, 8'hFF};
    op(CMSD_MODE_DIRECT, 8'h40);
    chk(32'({sel.ram_sel, sel.sfr_sel, sel.addr}), 32'h240);
    op(CMSD_MODE_INDIRECT, 8'h90);
    chk(32'({sel.ram_sel, sel.sfr_sel, sel.addr}), 32'h290);
    for (int i = 0; i < 7; i++) begin
      wr(CMSD_SFR_PAGE_SEL, pg[i]);
      op(CMSD_MODE_DIRECT, 8'h98);
      chk(32'({sel.ram_sel, sel.sfr_sel, sel.bit_capable, sel.page}),
          32'({1'b0, i < 5, 1'b1, pg[i]}));
      rd(CMSD_SFR_PROG_BANK, 8'h13);
    end
    wr(CMSD_SFR_PAGE_SEL, 8'h00);
    op(CMSD_MODE_DIRECT, 8'h9A);
    chk(32'({sel.sfr_sel, sel.bit_capable}), 32'h2);
  endtask : t_space

  task automatic t_regs();
    for (int b = 0; b < 4; b++) begin
      wr(CMSD_SFR_STATUS_WORD, 8'(b << 3));
      op(CMSD_MODE_REG, 8'h05);
      chk(32'({sel.ram_sel, sel.addr}), 32'({1'b1, 8'(b * 8 + 5)}));
      op(CMSD_MODE_PTR, 8'h07);
      chk(32'({sel.ram_sel, sel.addr}), 32'({1'b1, 8'(b * 8 + 1)}));
    end
    wr(CMSD_SFR_STATUS_WORD, 8'h00);
  endtask : t_regs

  task automatic t_bits();
    op(CMSD_MODE_BIT, 8'h13);
    chk(32'({sel.ram_sel, sel.is_bit, sel.addr, sel.bit_mask}), 32'h32208);
    op(CMSD_MODE_BIT, 8'h7F);
    chk(32'({sel.ram_sel, sel.is_bit, sel.addr, sel.bit_mask}), 32'h32F80);
    op(CMSD_MODE_DIRECT, 8'h22);
    chk(32'({sel.ram_sel, sel.is_bit, sel.addr}), 32'h222);
    op(CMSD_MODE_BIT, 8'h93);
    chk(32'({sel.sfr_sel, sel.is_bit, sel.addr, sel.bit_mask}), 32'h39008);
  endtask : t_bits

  task automatic t_stack();
    cpu.stack(6'h20);
    chk(32'({st_valid, st_addr, sp}), 32'h10808);
    cpu.stack(6'h08);
    chk(32'({st_valid, st_addr, sp, rec[7:0]}), 32'h1090A03);
    cpu.stack(6'h02);
    chk(32'({st_valid, sp}), 32'h0B);
    cpu.stack(6'h01);
    cpu.stack(6'h04);
    chk(32'({st_valid, st_addr, sp, rec[7:0]}), 32'h10A0800);
    cpu.stack(6'h10);
    chk(32'({st_valid, st_addr, sp, unf}), 32'h2100E);
    cpu.stack(6'h04);
    chk(32'({unf, sp}), 32'h105);
    cpu.clear();
    chk(32'(unf), 32'h0);
    repeat (32) cpu.stack(6'h20);
    chk(32'(ovf), 32'h0);
    cpu.stack(6'h20);
    chk(32'(ovf), 32'h1);
  endtask : t_stack

  task automatic t_store();
    cpu.code_op(16'h1234, 1'b0, 1'b1, 1'b0);
    chk(32'({cf_valid, x_valid, x_write, x_addr}), 32'h31234);
    wr(CMSD_SFR_STORE_CTL, 8'h01);
    cpu.code_op(16'h1234, 1'b0, 1'b1, 1'b0);
    chk(32'({cf_valid, cf_write, x_valid}), 32'h6);
    cpu.code_op(16'h1234, 1'b0, 1'b0, 1'b0);
    chk(32'({cf_valid, x_valid, x_write}), 32'h2);
    wr(CMSD_SFR_STORE_CTL, 8'h00);
  endtask : t_store

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    finish_test();
  end

  initial begin
    rst_b_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_reset();
    t_banks();
    t_space();
    t_regs();
    t_bits();
    t_stack();
    t_store();
    // A second reset in mid-run must bring back the reset program bank, stack pointer and empty record.
    rst_b_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    t_reset();
    finish_test();
  end
endmodule : tb_cmsd_decoder
